// File: src/ihp_params.svh
// constants for the ide host port: offsets, field positions, timing
// Operation
// R1: true ide only if output-enable strapped low
// R2: card drops dma request to pause
// R3: host dropping acknowledge only pauses transfer; in the ultra states a dropped acknowledge ends the burst instead
// R4: ultra write: strobe both edges, ready on iordy
// R5: ultra read: card toggles iordy per word
// R6: soft reset set holds reset, clear unconfigures
// R7: soft reset resets all but itself
// R8: interrupt style bit, one level, reset zero
// R9: six bit index resets zero, selects mode
// R10: host writes upper index bits as zero
// R11: ready-changed flag sets on ready change
// R12: bit one reads ready, masks flag write
// R13: socket register written before config index
// R14: drive number bit written zero, reads zero
// R15: acknowledge ignored while no dma active
// R16: stop from host ends ultra burst
// R17: host avoids invalid select combinations
`ifndef IHP_PARAMS_SVH
`define IHP_PARAMS_SVH
`define IHP_OFS_OPTION  10'h200
`define IHP_OFS_PINREP  10'h204
`define IHP_OFS_SOCKET  10'h206
`define IHP_OPT_SRST    7
`define IHP_OPT_LEVEL   6
`define IHP_PIN_CRDY    5
`define IHP_PIN_RRDY    1
`define IHP_PIN_ONES    8'h0C
`define IHP_SOCK_DRV    4
`define IHP_CLK_NS      50
`define IHP_DSTB_NS     112
`define IHP_DSTB_CYC    (((`IHP_DSTB_NS) + (`IHP_CLK_NS) - 1) / (`IHP_CLK_NS))
// strap samples must run past the three-stage pin chain and its filter so the last one is settled
`define IHP_STRAP_CYC   6
`endif

// File: src/ihp_pkg.sv
// types shared by the ide host port
package ihp_pkg;
  typedef enum logic [1:0] {
    IHP_IDLE,
    IHP_MWDMA,
    IHP_UDMA_WR,
    IHP_UDMA_RD
  } ihp_state_e;
endpackage

// File: src/ihp_port.sv
// ide host port: write fifo and the card-side port logic
`timescale 1ns/1ps
`include "ihp_params.svh"

// ==========================================
// fifo between the link capture and the core
module ihp_fifo #(
  parameter int W = 16,
  parameter int D = 8
) (
  input  wire logic         mclk,      // clock
  input  wire logic         reset_n,   // async reset
  input  wire logic         flush,     // sync clear
  input  wire logic         in_valid,  // push request
  output logic              in_ready,  // not full
  input  wire logic [W-1:0] in_data,   // push word
  output logic              out_valid, // not empty
  input  wire logic         out_ready, // pop request
  output logic [W-1:0]      out_data   // head word
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  generate
    if (D < 2 || (1 << AW) != D) begin : g_chk
      $error("ihp_fifo depth must be a power of two");
    end
  endgenerate
  logic [W-1:0]  mem_ff [D];          // storage
  logic [AW-1:0] wp_ff, nxt_wp;       // write pointer
  logic [AW-1:0] rp_ff, nxt_rp;       // read pointer
  logic [AW:0]   cnt_ff, nxt_cnt;     // fill level
  logic          push, pop;           // accepted moves
  // next pointers and level
  always_comb begin
    in_ready  = (cnt_ff != (AW+1)'(D));
    out_valid = (cnt_ff != '0);
    out_data  = mem_ff[rp_ff];
    push      = in_valid && in_ready;
    pop       = out_valid && out_ready;
    nxt_wp    = flush ? '0 : (push ? wp_ff + 1'b1 : wp_ff);
    nxt_rp    = flush ? '0 : (pop ? rp_ff + 1'b1 : rp_ff);
    nxt_cnt   = flush ? '0 : cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
  end
  // register pointers
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wp_ff  <= '0;
      rp_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      wp_ff  <= nxt_wp;
      rp_ff  <= nxt_rp;
      cnt_ff <= nxt_cnt;
    end
  end
  // storage needs no reset
  always_ff @(posedge mclk) begin
    if (push) begin
      mem_ff[wp_ff] <= in_data;
    end
  end
endmodule // ihp_fifo

// ==========================================
// card side of the parallel port
module ihp_port
  import ihp_pkg::*;
#(
  parameter int DEPTH = 8
) (
  input  wire logic        mclk,         // 20 MHz clock
  input  wire logic        reset_n,      // async reset, low
  input  wire logic        oe_n_pin,     // mode strap pin
  input  wire logic        cs0_n_pin,    // chip select 0
  input  wire logic        cs1_n_pin,    // chip select 1
  input  wire logic        dmack_n_pin,  // dma acknowledge
  input  wire logic        ior_n_pin,    // read strobe / hstrobe / hdmardy
  input  wire logic        iow_n_pin,    // write strobe / stop
  input  wire logic [15:0] dd_in,        // data pins in
  output logic [15:0]      dd_out,       // data pins out
  output logic             dd_oe,        // data drive enable
  output logic             dmarq,        // dma request
  output logic             iordy,        // iordy / ddmardy / dstrobe
  input  wire logic [9:0]  reg_addr,     // attribute address
  input  wire logic        reg_wr,       // write pulse
  input  wire logic        reg_rd,       // read pulse
  input  wire logic [7:0]  reg_wdata,    // write data
  output logic [7:0]       reg_rdata,    // read data
  output logic             true_ide,     // strap caught low
  output logic             card_reset,   // soft reset active
  output logic             irq_level,    // level irq style
  output logic [5:0]       cfg_index,    // configuration index
  output logic [3:0]       socket_copy,  // socket/copy field
  input  wire logic        card_ready,   // internal ready
  input  wire logic        dma_go,       // core wants dma
  input  wire logic        dma_dir,      // 1: card to host
  input  wire logic [15:0] rd_data,      // word to host
  input  wire logic        rd_valid,     // rd_data valid
  output logic             rd_taken,     // word taken pulse
  output logic [15:0]      wr_data,      // word from host
  output logic             wr_valid,     // wr_data valid
  input  wire logic        wr_ready      // core takes word
);
  localparam int SW = 22;               // synchronised pin count
  logic [SW-1:0] s1_ff, s2_ff, s3_ff;   // three stage chain
  logic [SW-1:0] st_ff, nxt_st;         // filtered levels
  logic [15:0]   d_s;                   // filtered data
  logic          ack, ior_s, iow_s;     // filtered strobes
  logic          ior_rise, ior_edge, iow_rise;
  ihp_state_e    state_ff, nxt_state;   // transfer state
  logic          dmarq_ff, nxt_dmarq;
  logic          iordy_ff, nxt_iordy;
  logic [15:0]   dout_ff, nxt_dout;
  logic          doe_ff, nxt_doe;
  logic          taken_ff, nxt_taken;
  logic [1:0]    cnt_ff, nxt_cnt;       // dstrobe spacing
  logic          push;                  // capture word
  logic          f_ready;               // fifo has room
  logic          srst_ff, nxt_srst;     // soft reset bit
  logic          lvl_ff, nxt_lvl;
  logic [5:0]    idx_ff, nxt_idx;
  logic          crdy_ff, nxt_crdy;     // ready changed
  logic          rprev_ff;              // last ready level
  logic [3:0]    sock_ff, nxt_sock;
  logic [7:0]    rdat_ff, nxt_rdat;
  logic [2:0]    scnt_ff, nxt_scnt;     // strap settle count
  logic          ide_ff, nxt_ide;
  logic          wr_opt, wr_pin, wr_sock;

  // ==========================================
  // pin synchronisers
  always_comb begin
    nxt_st = st_ff;
    if (s2_ff == s3_ff) begin
      nxt_st = s3_ff;
    end
  end
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s1_ff <= {6'h3F, 16'h0000};
      s2_ff <= {6'h3F, 16'h0000};
      s3_ff <= {6'h3F, 16'h0000};
      st_ff <= {6'h3F, 16'h0000};
    end else begin
      s1_ff <= {oe_n_pin, cs0_n_pin, cs1_n_pin, dmack_n_pin, ior_n_pin, iow_n_pin, dd_in};
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      st_ff <= nxt_st;
    end
  end
  // both selects high is the only legal dma decode
  assign ack   = !st_ff[18] && st_ff[20] && st_ff[19]; // R17
  assign ior_s = st_ff[17];
  assign iow_s = st_ff[16];
  assign d_s   = st_ff[15:0];
  assign ior_rise = nxt_st[17] && !ior_s;
  assign ior_edge = nxt_st[17] != ior_s;
  assign iow_rise = nxt_st[16] && !iow_s;

  // ==========================================
  // write fifo
  ihp_fifo #(.W(16), .D(DEPTH)) u_fifo (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .flush     (srst_ff),
    .in_valid  (push),
    .in_ready  (f_ready),
    .in_data   (d_s),
    .out_valid (wr_valid),
    .out_ready (wr_ready),
    .out_data  (wr_data)
  );

  // ==========================================
  // transfer state machine
  always_comb begin
    nxt_state = state_ff;
    nxt_dmarq = dmarq_ff;
    nxt_iordy = 1'b1;
    nxt_dout  = dout_ff;
    nxt_doe   = 1'b0;
    nxt_taken = 1'b0;
    nxt_cnt   = (cnt_ff != 2'd0) ? cnt_ff - 2'd1 : 2'd0;
    push      = 1'b0;
    unique case (state_ff)
      IHP_IDLE: begin
        nxt_dmarq = dma_go && ide_ff;
        // acknowledge counts only against our own request
        if (dmarq_ff && ack) begin // R15
          if (idx_ff == 6'h00) begin
            nxt_state = IHP_MWDMA;
          end else if (dma_dir) begin
            nxt_state = IHP_UDMA_RD;
            nxt_iordy = 1'b0;
          end else begin
            nxt_state = IHP_UDMA_WR;
          end
        end
      end
      IHP_MWDMA: begin
        // drop request while no room or no word
        nxt_dmarq = dma_go && (dma_dir ? rd_valid : f_ready); // R2
        nxt_dout  = rd_data;
        if (ack && dma_dir && !ior_s) begin
          nxt_doe = 1'b1;
        end
        if (ack && dma_dir && ior_rise) begin
          nxt_taken = 1'b1;
        end
        if (ack && !dma_dir && iow_rise) begin
          push = 1'b1;
        end
        // a released acknowledge only pauses
        if (!dma_go && !ack) begin // R3
          nxt_state = IHP_IDLE;
        end
      end
      IHP_UDMA_WR: begin
        nxt_iordy = !f_ready;               // R4
        push      = ack && ior_edge;        // R4
        if (iow_s || !ack) begin // R16
          nxt_state = IHP_IDLE;
          nxt_dmarq = 1'b0;
        end
      end
      IHP_UDMA_RD: begin
        nxt_doe   = 1'b1;
        nxt_iordy = iordy_ff;
        if (cnt_ff == 2'd1) begin
          nxt_iordy = !iordy_ff;            // R5
        end
        if (cnt_ff == 2'd0 && !ior_s && rd_valid && !taken_ff) begin
          nxt_dout  = rd_data;              // R5
          nxt_taken = 1'b1;
          nxt_cnt   = 2'(`IHP_DSTB_CYC);
        end
        if (iow_s || !ack) begin // R16
          nxt_state = IHP_IDLE;
          nxt_dmarq = 1'b0;
          nxt_doe   = 1'b0;
          nxt_iordy = 1'b1;
        end
      end
    endcase
    if (srst_ff) begin // R7
      nxt_state = IHP_IDLE;
      nxt_dmarq = 1'b0;
      nxt_doe   = 1'b0;
      nxt_iordy = 1'b1;
      nxt_taken = 1'b0;
      nxt_cnt   = 2'd0;
    end
  end
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= IHP_IDLE;
      dmarq_ff <= 1'b0;
      iordy_ff <= 1'b1;
      dout_ff  <= 16'h0000;
      doe_ff   <= 1'b0;
      taken_ff <= 1'b0;
      cnt_ff   <= 2'd0;
    end else begin
      state_ff <= nxt_state;
      dmarq_ff <= nxt_dmarq;
      iordy_ff <= nxt_iordy;
      dout_ff  <= nxt_dout;
      doe_ff   <= nxt_doe;
      taken_ff <= nxt_taken;
      cnt_ff   <= nxt_cnt;
    end
  end

  // ==========================================
  // attribute registers
  assign wr_opt  = reg_wr && reg_addr == `IHP_OFS_OPTION;
  assign wr_pin  = reg_wr && reg_addr == `IHP_OFS_PINREP;
  assign wr_sock = reg_wr && reg_addr == `IHP_OFS_SOCKET;
  always_comb begin
    nxt_srst = wr_opt ? reg_wdata[`IHP_OPT_SRST] : srst_ff; // R6
    nxt_lvl  = wr_opt ? reg_wdata[`IHP_OPT_LEVEL] : lvl_ff;  // R8
    nxt_idx  = wr_opt ? reg_wdata[5:0] : idx_ff;             // R9
    nxt_sock = wr_sock ? reg_wdata[3:0] : sock_ff;           // R14
    nxt_crdy = crdy_ff;
    if (wr_pin && reg_wdata[`IHP_PIN_RRDY]) begin // R12
      nxt_crdy = reg_wdata[`IHP_PIN_CRDY];
    end
    // a ready change beats a host clear
    if (card_ready != rprev_ff) begin // R11
      nxt_crdy = 1'b1;
    end
    // soft reset clears all but its own bit
    if (srst_ff) begin // R7
      nxt_lvl  = 1'b0;
      nxt_idx  = 6'h00;
      nxt_sock = 4'h0;
      nxt_crdy = 1'b0;
    end
    nxt_rdat = rdat_ff;
    if (reg_rd) begin
      unique case (reg_addr)
        `IHP_OFS_OPTION: nxt_rdat = {srst_ff, lvl_ff, idx_ff};
        `IHP_OFS_PINREP: nxt_rdat = `IHP_PIN_ONES | {2'b00, crdy_ff, 3'b000, card_ready, 1'b0}; // R12
        `IHP_OFS_SOCKET: nxt_rdat = 8'h00; // R14
        default:         nxt_rdat = 8'h00;
      endcase
    end
  end
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      srst_ff  <= 1'b0;
      lvl_ff   <= 1'b0;
      idx_ff   <= 6'h00;
      sock_ff  <= 4'h0;
      crdy_ff  <= 1'b0;
      rprev_ff <= 1'b0;
      rdat_ff  <= 8'h00;
    end else begin
      srst_ff  <= nxt_srst;
      lvl_ff   <= nxt_lvl;
      idx_ff   <= nxt_idx;
      sock_ff  <= nxt_sock;
      crdy_ff  <= nxt_crdy;
      rprev_ff <= card_ready;
      rdat_ff  <= nxt_rdat;
    end
  end

  // ==========================================
  // mode strap, caught once the chain has settled
  always_comb begin
    nxt_scnt = scnt_ff;
    nxt_ide  = ide_ff;
    if (scnt_ff != 3'(`IHP_STRAP_CYC)) begin
      nxt_scnt = scnt_ff + 3'd1;
      nxt_ide  = !st_ff[21]; // R1
    end
  end
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      scnt_ff <= 3'd0;
      ide_ff  <= 1'b0;
    end else begin
      scnt_ff <= nxt_scnt;
      ide_ff  <= nxt_ide;
    end
  end

  // ==========================================
  // outputs
  assign dd_out      = dout_ff;
  assign dd_oe       = doe_ff;
  assign dmarq       = dmarq_ff;
  assign iordy       = iordy_ff;
  assign reg_rdata   = rdat_ff;
  assign true_ide    = ide_ff;
  assign card_reset  = srst_ff;
  assign irq_level   = lvl_ff;
  assign cfg_index   = idx_ff;
  assign socket_copy = sock_ff;
  assign rd_taken    = taken_ff;
endmodule // ihp_port

// File: tb/ihp_port_properties.sv
// concurrent checks on the card-side port pins and registers
`timescale 1ns/1ps
`include "ihp_params.svh"
module ihp_port_properties (
  input wire logic       mclk,        // clock
  input wire logic       reset_n,     // async reset
  input wire logic       dmack_n_pin, // acknowledge pin
  input wire logic       iow_n_pin,   // write strobe / stop
  input wire logic       dd_oe,       // card drives data
  input wire logic       dmarq,       // dma request
  input wire logic       iordy,       // ready / strobe
  input wire logic [9:0] reg_addr,    // register address
  input wire logic       reg_wr,      // write pulse
  input wire logic       reg_rd,      // read pulse
  input wire logic [7:0] reg_rdata,   // read data
  input wire logic       true_ide,    // strap caught
  input wire logic       card_reset,  // soft reset bit
  input wire logic       irq_level,   // interrupt style
  input wire logic [5:0] cfg_index,   // config index
  input wire logic       card_ready   // internal ready
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // ==========================================
  // register checks
  chk_reset_clear: assert property ($rose(reset_n) |-> cfg_index == 6'h00 && !irq_level)
    else $error("option fields not cleared by reset");
  chk_option_read: assert property (reg_rd && reg_addr == `IHP_OFS_OPTION |=>
    reg_rdata[7] == $past(card_reset) && reg_rdata[5:0] == $past(cfg_index)) else $error("option read wrong");
  chk_pin_read: assert property (reg_rd && reg_addr == `IHP_OFS_PINREP |=>
    {reg_rdata[7:6], reg_rdata[4:0]} == {5'h03, $past(card_ready), 1'b0}) else $error("pin read wrong");
  chk_socket_zero: assert property (reg_rd && reg_addr == `IHP_OFS_SOCKET |=> reg_rdata == 8'h00)
    else $error("socket read not zero");
  chk_srst_clears: assert property (card_reset && $past(card_reset) |-> cfg_index == 6'h00 && !irq_level)
    else $error("soft reset left state");
  chk_srst_holds: assert property (card_reset && !(reg_wr && reg_addr == `IHP_OFS_OPTION) |=> card_reset)
    else $error("soft reset bit cleared itself");
  // ==========================================
  // link checks
  chk_strap_gate: assert property (!true_ide |-> !dmarq && !dd_oe)
    else $error("dma activity outside true ide");
  chk_ack_ignored: assert property ($rose(dd_oe) |-> $past(dmarq))
    else $error("drive without request");
  chk_stop_ends: assert property (cfg_index != 6'h00 && dmarq && !dmack_n_pin && $rose(iow_n_pin)
    |-> ##[1:10] (!dmarq && !dd_oe)) else $error("stop did not end burst");
  chk_dstrobe_gap: assert property (dd_oe && $changed(iordy) |=> ($stable(iordy) || !dd_oe)[*2])
    else $error("strobe edges too close");
  cover property (dd_oe && $changed(iordy));
  cover property (card_reset);
  cover property (dmarq && !dmack_n_pin && !iordy && !dd_oe);
endmodule // ihp_port_properties
bind ihp_port ihp_port_properties u_props (.*);

// File: tb/ihp_host_model.sv
// host controller model driving the card's parallel port pins
`timescale 1ns/1ps
module ihp_host_model (
  input  wire logic        dmarq,   // card request
  input  wire logic        iordy,   // ready / strobe from card
  input  wire logic [15:0] dd_out,  // card data
  output logic             cs0_n,   // chip select 0
  output logic             cs1_n,   // chip select 1
  output logic             dmack_n, // acknowledge
  output logic             ior_n,   // strobe / ready
  output logic             iow_n,   // write strobe / stop
  output logic [15:0]      dd       // host data
);
  logic [15:0] sent[$]; // words put on the bus
  logic [15:0] got[$];  // words caught on card strobe
  // idle: both selects off, never combined with ack
  initial begin
    {cs0_n, cs1_n, dmack_n, ior_n, iow_n} = 5'h1F;
    dd = 16'hA5A5;
  end
  // multiword write, acknowledge dropped once mid-way
  task automatic mw_write(input int n);
    wait (dmarq);
    dmack_n = 1'b0;
    #400;
    for (int k = 0; k < n; k++) begin
      if (k == 3) begin
        dmack_n = 1'b1;
        #400;
        dmack_n = 1'b0;
        #400;
      end
      dd = 16'($urandom);
      sent.push_back(dd);
      wait (dmarq);
      #200;
      iow_n = 1'b0;
      #200;
      iow_n = 1'b1;
      #400;
    end
    dmack_n = 1'b1;
  endtask
  // ultra burst, rd high for card to host
  task automatic burst(input bit rd, input int n);
    wait (dmarq);
    {dmack_n, iow_n, ior_n} = {2'b00, !rd};
    if (rd) dd = ~dd;
    #400;
    repeat (n) begin
      if (rd) begin
        @(iordy);
        got.push_back(dd_out);
      end else begin
        dd = 16'($urandom);
        sent.push_back(dd);
        #200;
        wait (!iordy);
        ior_n = !ior_n;
        #200;
      end
    end
    iow_n = 1'b1;
    #400;
    {dmack_n, ior_n} = 2'b11;
    dd = ~dd; // released bus shows no stale word
  endtask
endmodule // ihp_host_model

// File: tb/tb.sv
// self-checking bench for the card-side port
`timescale 1ns/1ps
`include "ihp_params.svh"
module tb;
  logic mclk = 0, reset_n = 0, reg_wr, reg_rd, card_ready, dma_go, dma_dir, wr_ready;
  logic cs0_n, cs1_n, dmack_n, ior_n, iow_n, dd_oe, dmarq, iordy, rd_taken, wr_valid;
  logic [15:0] dd, dd_out, rd_data, wr_data;
  logic [9:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, v;
  logic ide;          // strap result
  logic [3:0] sock;   // stored socket field
  logic [15:0] wq[$], eq[$]; // words popped, words handed out
  int error_cnt = 0, checks = 0;
  // ==========================================
  // clock, design and host
  initial forever #25 mclk = ~mclk;
  ihp_port #(.DEPTH(8)) u_dut (.mclk(mclk), .reset_n(reset_n), .oe_n_pin(1'b0), .cs0_n_pin(cs0_n),
    .cs1_n_pin(cs1_n), .dmack_n_pin(dmack_n), .ior_n_pin(ior_n), .iow_n_pin(iow_n), .dd_in(dd),
    .dd_out(dd_out), .dd_oe(dd_oe), .dmarq(dmarq), .iordy(iordy), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .true_ide(ide), .card_reset(),
    .irq_level(), .cfg_index(), .socket_copy(sock), .card_ready(card_ready), .dma_go(dma_go),
    .dma_dir(dma_dir), .rd_data(rd_data), .rd_valid(1'b1), .rd_taken(rd_taken), .wr_data(wr_data),
    .wr_valid(wr_valid), .wr_ready(wr_ready));
  ihp_host_model u_host (.dmarq(dmarq), .iordy(iordy), .dd_out(dd_out), .cs0_n(cs0_n), .cs1_n(cs1_n),
    .dmack_n(dmack_n), .ior_n(ior_n), .iow_n(iow_n), .dd(dd));
  // collect popped words and supply read words
  always @(posedge mclk) begin
    if (wr_valid && wr_ready) wq.push_back(wr_data);
    if (rd_taken) begin
      eq.push_back(rd_data);
      rd_data <= 16'($urandom);
    end
  end
  // ==========================================
  // helpers
  function automatic logic [7:0] pin_exp(input logic crdy, input logic rdy);
    return 8'h0C | {2'b00, crdy, 3'b000, rdy, 1'b0};
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    chk({8'h00, reg_rdata}, {8'h00, e});
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // watchdog
  initial begin
    #2000000;
    error_cnt++;
    report_and_stop();
  end
  // ==========================================
  // main sequence
  initial begin
    {reg_wr, reg_rd, card_ready, dma_go, dma_dir, wr_ready} = 6'h00;
    reg_addr = 10'h000;
    reg_wdata = 8'h00;
    rd_data = 16'h0000;
    void'($urandom(32'hBF80));
    repeat (16) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (4) @(posedge mclk);
    rd(`IHP_OFS_OPTION, 8'h00);
    rd(`IHP_OFS_PINREP, pin_exp(1'b0, 1'b0));
    rd(10'h3FF, 8'h00);
    chk({15'h0000, ide}, 16'h0001);
    v = 8'h0F & 8'($urandom);
    wr(`IHP_OFS_SOCKET, v);
    rd(`IHP_OFS_SOCKET, 8'h00);
    chk({12'h000, sock}, {12'h000, v[3:0]});
    repeat (6) begin
      v = 8'($urandom) & 8'h4F;
      wr(`IHP_OFS_OPTION, v);
      rd(`IHP_OFS_OPTION, v);
    end
    card_ready <= 1'b1;
    repeat (3) @(posedge mclk);
    rd(`IHP_OFS_PINREP, pin_exp(1'b1, 1'b1));
    wr(`IHP_OFS_PINREP, 8'h00);
    rd(`IHP_OFS_PINREP, pin_exp(1'b1, 1'b1));
    wr(`IHP_OFS_PINREP, 8'h02);
    rd(`IHP_OFS_PINREP, pin_exp(1'b0, 1'b1));
    wr(`IHP_OFS_OPTION, 8'hC5);
    rd(`IHP_OFS_OPTION, 8'h80);
    wr(`IHP_OFS_OPTION, 8'h00);
    rd(`IHP_OFS_OPTION, 8'h00);
    // multiword write: card pauses by dropping its request
    dma_go <= 1'b1;
    fork
      u_host.mw_write(10);
      begin
        wait (u_host.sent.size() == 9);
        repeat (16) @(posedge mclk);
        chk({15'h0000, dmarq}, 16'h0000);
        wr_ready <= 1'b1;
      end
    join
    @(posedge mclk);
    dma_go <= 1'b0;
    repeat (30) @(posedge mclk);
    chk(16'(wq.size()), 16'd10);
    foreach (wq[i]) chk(wq[i], u_host.sent[i]);
    wq.delete();
    u_host.sent.delete();
    wr_ready <= 1'b0;
    // ultra write: fill while stalled, then drain
    wr(`IHP_OFS_OPTION, 8'h01);
    dma_go <= 1'b1;
    fork
      u_host.burst(1'b0, 10);
      begin
        wait (u_host.sent.size() == 9);
        repeat (16) @(posedge mclk);
        chk({15'h0000, iordy}, 16'h0001);
        wr_ready <= 1'b1;
      end
    join
    @(posedge mclk);
    dma_go <= 1'b0;
    repeat (30) @(posedge mclk);
    chk(16'(wq.size()), 16'd10);
    foreach (wq[i]) chk(wq[i], u_host.sent[i]);
    chk({15'h0000, wr_valid}, 16'h0000);
    // ultra read: card strobes words to host
    dma_dir <= 1'b1;
    rd_data <= 16'($urandom);
    dma_go <= 1'b1;
    fork
      u_host.burst(1'b1, 12);
      begin
        wait (u_host.got.size() == 12);
        @(posedge mclk);
        dma_go <= 1'b0;
      end
    join
    repeat (30) @(posedge mclk);
    for (int i = 0; i < 12; i++) chk(u_host.got[i], eq[i]);
    report_and_stop();
  end
endmodule // tb
